// ### clock_mode_ctrl.sv
// Notes on behaviour
// - system clock from crystal or on-chip oscillator
// - cpu clock is system clock divided
// - div8 bit wins, else field 1/2/4/16
// - reset: slow on-chip oscillator, divide by 8
// - stop from high-speed mode sets div8
// - peripheral clocks f1 f2 f4 f8 f32
// - peripheral clocks halt in wait if latched
// - aux clock follows on-chip oscillator, runs in wait
// - fast timer clock from fast oscillator when enabled
// - converter clock from fast oscillator when enabled
// - supervisory clock while slow oscillator on
// - aux clock divided by 128 for capture
// - high-speed mode uses main crystal
// - low-speed mode uses sub crystal
// - fast oscillator feeds cpu when on-chip select, enable and fast select set
// - slow oscillator feeds cpu when select low
// - aux clock available if either oscillator on
// - main crystal stopped until software enables
`timescale 1ns/10ps
`default_nettype none
module clock_mode_ctrl
    import clkmode_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic main_crystal_clock,
    input wire logic sub_crystal_clock,
    input wire logic fast_osc_clock,
    input wire logic slow_osc_clock,
    input wire logic wake_event,
    output logic cpu_clk_en,
    output logic [NUM_PCLK-1:0] periph_clk,
    output aux_clk_t aux_clk,
    output logic main_crystal_run,
    output logic sub_crystal_run,
    output logic fast_osc_run,
    output logic slow_osc_run,
    output logic flash_low_current_read,
    output logic internal_low_power_enable,
    output logic in_wait,
    output logic in_stop
);
    ctrl_t ctrl;
    pmode_t pm;
    src_t act_src;
    logic [3:0] act_last;
    logic [3:0] cpu_cnt;
    logic [4:0] pcnt;
    logic [6:0] acnt;
    logic [4:0] scnt;
    logic halt_latch;
    logic [NUM_OSC-1:0] osc_raw;
    logic [NUM_OSC-1:0] osc_rise;
    logic [NUM_OSC-1:0] tick;
    logic sys_tick;
    logic aux_tick;
    logic aux_fast;
    logic periph_halt;
    logic do_write;
    logic wb_hit;
    logic cmd_wait;
    logic cmd_stop;
    logic ctrl_wr;
    stat_t stat;

    ////////////////////////////////////////////////////////////////////////
    // oscillator inputs

    assign osc_raw[OSC_MAIN] = main_crystal_clock;
    assign osc_raw[OSC_SUB] = sub_crystal_clock;
    assign osc_raw[OSC_FAST] = fast_osc_clock;
    assign osc_raw[OSC_SLOW] = slow_osc_clock;

    generate
        for (genvar i = 0; i < NUM_OSC; i++) begin : g_osc
            osc_sync u_sync (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .raw(osc_raw[i]),
                .rise(osc_rise[i])
            );
        end
    endgenerate

    // an oscillator that is not running yields no ticks even if the pin toggles
    assign tick[OSC_MAIN] = osc_rise[OSC_MAIN] & main_crystal_run;
    assign tick[OSC_SUB] = osc_rise[OSC_SUB] & sub_crystal_run;
    assign tick[OSC_FAST] = osc_rise[OSC_FAST] & fast_osc_run;
    assign tick[OSC_SLOW] = osc_rise[OSC_SLOW] & slow_osc_run;

    assign sys_tick = tick[act_src];

    // on-chip oscillator clock: fast when enabled and selected, or when enabled and slow one is off
    assign aux_fast = ctrl.fast_osc_enable & (ctrl.onchip_osc_fast_select | ctrl.slow_osc_off);
    assign aux_tick = aux_fast ? tick[OSC_FAST] : tick[OSC_SLOW];

    ////////////////////////////////////////////////////////////////////////
    // oscillator run controls

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            main_crystal_run <= 1'b0;
            sub_crystal_run <= 1'b0;
            fast_osc_run <= 1'b0;
            slow_osc_run <= 1'b1;
        end else begin
            // every oscillator stops in stop mode
            main_crystal_run <= ctrl.main_crystal_pin_select && !ctrl.main_crystal_stop
                && pm != PM_STOP;
            sub_crystal_run <= ctrl.crystal_source_select && ctrl.sub_crystal_pin_enable
                && pm != PM_STOP;
            fast_osc_run <= ctrl.fast_osc_enable && pm != PM_STOP;
            // slow oscillator kept alive while the control register selects it as cpu source
            slow_osc_run <= (!ctrl.slow_osc_off || pick_source(ctrl) == SRC_SLOW)
                && pm != PM_STOP;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave

    assign wb_hit = wb_cyc_i & wb_stb_i & !wb_ack_o;
    // writes land on the edge where the master samples ack
    assign do_write = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign ctrl_wr = do_write && wb_adr_i == OFS_CTRL;
    assign cmd_wait = do_write && wb_adr_i == OFS_CMD && wb_sel_i[0] && wb_dat_i[CMD_WAIT_BIT];
    assign cmd_stop = do_write && wb_adr_i == OFS_CMD && wb_sel_i[0] && wb_dat_i[CMD_STOP_BIT];

    always_comb begin
        stat = '0;
        stat.slow_run = slow_osc_run;
        stat.fast_run = fast_osc_run;
        stat.sub_run = sub_crystal_run;
        stat.main_run = main_crystal_run;
        stat.pm = pm;
        stat.src = act_src;
        stat.div_last = act_last;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_hit;
            if (wb_hit) begin
                unique case (wb_adr_i)
                    OFS_CTRL: wb_dat_o <= {16'h0000, ctrl};
                    OFS_STAT: wb_dat_o <= stat;
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl <= CTRL_RESET;
        end else begin
            if (ctrl_wr && wb_sel_i[0])
                ctrl[7:0] <= wb_dat_i[7:0];
            if (ctrl_wr && wb_sel_i[1])
                ctrl[15:8] <= {2'h0, wb_dat_i[13:8]};
            // stop taken from crystal high-speed mode forces divide by 8
            if (pm == PM_RUN && cmd_stop && act_src == SRC_MAIN)
                ctrl.cpu_div8_select <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flash_low_current_read <= 1'b0;
            internal_low_power_enable <= 1'b0;
        end else begin
            flash_low_current_read <= ctrl.flash_low_current_read;
            internal_low_power_enable <= ctrl.internal_low_power_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power mode

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pm <= PM_RUN;
            halt_latch <= 1'b0;
        end else begin
            unique case (pm)
                PM_RUN: begin
                    if (cmd_stop)
                        pm <= PM_STOP;
                    else if (cmd_wait) begin
                        pm <= PM_WAIT;
                        halt_latch <= ctrl.periph_clk_stop_in_wait;
                    end
                end
                PM_WAIT: begin
                    if (wake_event)
                        pm <= PM_RUN;
                end
                PM_STOP: begin
                    if (wake_event)
                        pm <= PM_RUN;
                end
                default: pm <= PM_RUN;
            endcase
        end
    end

    assign periph_halt = pm == PM_WAIT && halt_latch;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            in_wait <= 1'b0;
            in_stop <= 1'b0;
        end else begin
            in_wait <= pm == PM_WAIT;
            in_stop <= pm == PM_STOP;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cpu clock divider

    // ratio and source switch only at a period boundary, so no runt pulse;
    // the old source must keep running until that boundary is reached
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cpu_cnt <= 4'h0;
            act_src <= SRC_SLOW;
            act_last <= DIV8_LAST;
            cpu_clk_en <= 1'b0;
        end else begin
            cpu_clk_en <= 1'b0;
            if (sys_tick) begin
                if (cpu_cnt == act_last) begin
                    cpu_cnt <= 4'h0;
                    cpu_clk_en <= pm == PM_RUN;
                    act_src <= pick_source(ctrl);
                    act_last <= div_last(ctrl);
                end else begin
                    cpu_cnt <= cpu_cnt + 4'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // peripheral clocks

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pcnt <= 5'h00;
            periph_clk <= '0;
        end else begin
            if (sys_tick && !periph_halt)
                pcnt <= pcnt + 5'h01;
            for (int i = 0; i < NUM_PCLK; i++)
                periph_clk[i] <= sys_tick && !periph_halt && (pcnt & PCLK_MASK[i]) == 5'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator-derived clocks, none gated by wait

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            acnt <= 7'h00;
            scnt <= 5'h00;
            aux_clk <= '0;
        end else begin
            if (aux_tick)
                acnt <= acnt + 7'h01;
            if (tick[OSC_SUB])
                scnt <= scnt + 5'h01;
            aux_clk.aux_osc_clock <= aux_tick;
            aux_clk.fast_timer_count_clock <= tick[OSC_FAST];
            aux_clk.converter_count_clock <= tick[OSC_FAST];
            aux_clk.slow_supervisor_clock <= tick[OSC_SLOW] && !ctrl.slow_osc_off;
            aux_clk.aux_osc_div128_clock <= aux_tick && acnt == AUX128_LAST;
            aux_clk.sub_crystal_div4_clock <= tick[OSC_SUB] && scnt[1:0] == SUB4_LAST;
            aux_clk.sub_crystal_div32_clock <= tick[OSC_SUB] && scnt == SUB32_LAST;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence seq_stop_hs;
        pm == PM_RUN && cmd_stop && act_src == SRC_MAIN;
    endsequence

    sequence seq_wait_entry;
        pm == PM_RUN && cmd_wait && !cmd_stop ##1 pm == PM_WAIT;
    endsequence

    sequence seq_boundary;
        sys_tick && cpu_cnt == act_last;
    endsequence

    AST_RESET_STATE: assert property (
        $fell(sys_rst) |-> ctrl.cpu_div8_select && ctrl.onchip_osc_system_select
            && act_src == SRC_SLOW && act_last == DIV8_LAST && !main_crystal_run)
        else $error("reset state not slow oscillator divide by 8");

    AST_CPU_RATIO: assert property (
        seq_boundary |=> act_last == div_last($past(ctrl)))
        else $error("cpu ratio not taken from control at boundary");

    AST_SRC_SEL: assert property (
        seq_boundary |=> act_src == pick_source($past(ctrl)))
        else $error("cpu source not taken from control at boundary");

    AST_NO_RUNT: assert property (
        (sys_tick && cpu_cnt != act_last) |=> $stable(act_last) && $stable(act_src))
        else $error("ratio or source changed inside a cpu period");

    AST_CPU_PULSE: assert property (
        (seq_boundary and pm == PM_RUN) |=> cpu_clk_en ##1 !cpu_clk_en)
        else $error("cpu clock pulse missing at boundary");

    AST_STOP_DIV8: assert property (
        seq_stop_hs |=> pm == PM_STOP && ctrl.cpu_div8_select ##1 !main_crystal_run)
        else $error("stop from high-speed mode did not set divide by 8");

    AST_WAIT_CPU_OFF: assert property (
        seq_wait_entry |=> !cpu_clk_en)
        else $error("cpu clock still running in wait");

    AST_PERIPH_HALT: assert property (
        periph_halt |=> periph_clk == '0)
        else $error("peripheral clock running while halted in wait");

    AST_PERIPH_RUN: assert property (
        (pm == PM_WAIT && !halt_latch && sys_tick) |=> periph_clk[0])
        else $error("f1 stopped in wait without halt");

    AST_MAIN_OFF: assert property (
        ctrl.main_crystal_stop |=> !main_crystal_run)
        else $error("main crystal running while stopped");

    AST_FAST_GATE: assert property (
        (!fast_osc_run || !osc_rise[OSC_FAST]) |=> !aux_clk.fast_timer_count_clock
            && !aux_clk.converter_count_clock)
        else $error("fast count clocks without fast oscillator");

    AST_SLOW_GATE: assert property (
        ctrl.slow_osc_off |=> !aux_clk.slow_supervisor_clock)
        else $error("supervisory clock while slow oscillator off");

    AST_AUX_WAIT: assert property (
        (pm == PM_WAIT && aux_tick) |=> aux_clk.aux_osc_clock)
        else $error("aux clock stopped in wait");

    AST_DIV128: assert property (
        aux_clk.aux_osc_div128_clock |-> $past(aux_tick) && acnt == 7'h00)
        else $error("div128 pulse off its count");
endmodule // clock_mode_ctrl
`default_nettype wire

// ### clkmode_pkg.sv
`default_nettype none
package clkmode_pkg;
    // register word offsets on the bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam int unsigned CMD_WAIT_BIT = 0;
    localparam int unsigned CMD_STOP_BIT = 1;

    // oscillator input index
    localparam int unsigned NUM_OSC = 4;
    localparam int unsigned OSC_MAIN = 0;
    localparam int unsigned OSC_SUB = 1;
    localparam int unsigned OSC_FAST = 2;
    localparam int unsigned OSC_SLOW = 3;

    // peripheral clocks f1, f2, f4, f8, f32 as counter masks
    localparam int unsigned NUM_PCLK = 5;
    localparam logic [4:0] PCLK_MASK [NUM_PCLK] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h1F};

    // cpu divider terminal counts (ratio minus one)
    localparam logic [3:0] DIV1_LAST = 4'h0;
    localparam logic [3:0] DIV2_LAST = 4'h1;
    localparam logic [3:0] DIV4_LAST = 4'h3;
    localparam logic [3:0] DIV8_LAST = 4'h7;
    localparam logic [3:0] DIV16_LAST = 4'hF;

    localparam logic [6:0] AUX128_LAST = 7'h7F;
    localparam logic [1:0] SUB4_LAST = 2'h3;
    localparam logic [4:0] SUB32_LAST = 5'h1F;

    typedef enum logic [1:0] {SRC_MAIN, SRC_SUB, SRC_FAST, SRC_SLOW} src_t;
    typedef enum logic [1:0] {PM_RUN, PM_WAIT, PM_STOP} pmode_t;

    typedef struct packed {
        logic [1:0] reserved;
        logic internal_low_power_enable;
        logic flash_low_current_read;
        logic onchip_osc_fast_select;
        logic fast_osc_enable;
        logic onchip_osc_system_select;
        logic crystal_source_select;
        logic sub_crystal_pin_enable;
        logic main_crystal_stop;
        logic slow_osc_off;
        logic main_crystal_pin_select;
        logic periph_clk_stop_in_wait;
        logic cpu_div_field_high;
        logic cpu_div_field_low;
        logic cpu_div8_select;
    } ctrl_t;

    // div8 set, main crystal stopped, on-chip (slow) oscillator selected
    localparam logic [15:0] CTRL_RESET = 16'h0241;

    typedef struct packed {
        logic [19:0] zero;
        logic slow_run;
        logic fast_run;
        logic sub_run;
        logic main_run;
        pmode_t pm;
        src_t src;
        logic [3:0] div_last;
    } stat_t;

    typedef struct packed {
        logic aux_osc_clock;
        logic fast_timer_count_clock;
        logic converter_count_clock;
        logic slow_supervisor_clock;
        logic aux_osc_div128_clock;
        logic sub_crystal_div4_clock;
        logic sub_crystal_div32_clock;
    } aux_clk_t;

    function automatic src_t pick_source(input ctrl_t c);
        if (c.onchip_osc_system_select)
            pick_source = (c.fast_osc_enable && c.onchip_osc_fast_select) ? SRC_FAST : SRC_SLOW;
        else
            pick_source = c.crystal_source_select ? SRC_SUB : SRC_MAIN;
    endfunction

    function automatic logic [3:0] div_last(input ctrl_t c);
        if (c.cpu_div8_select)
            div_last = DIV8_LAST;
        else begin
            unique case ({c.cpu_div_field_high, c.cpu_div_field_low})
                2'h0: div_last = DIV1_LAST;
                2'h1: div_last = DIV2_LAST;
                2'h2: div_last = DIV4_LAST;
                2'h3: div_last = DIV16_LAST;
            endcase
        end
    endfunction
endpackage
`default_nettype wire

// ### osc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module osc_sync
    import clkmode_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic raw,
    output logic rise
);
    logic [2:0] sync;
    logic level;

    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            sync <= 3'h0;
        else
            sync <= {sync[1:0], raw};
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            level <= 1'b0;
            rise <= 1'b0;
        end else begin
            rise <= (sync[1] == sync[2]) && sync[2] && !level;
            if (sync[1] == sync[2])
                level <= sync[2];
        end
    end
endmodule // osc_sync
`default_nettype wire

// ### tb_clock_mode_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tb_clock_mode_ctrl
    import clkmode_pkg::*;
;
    typedef struct {string name; logic [31:0] v;} note_t;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, wake = 1'b0, mstb = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, mval = 32'h0, rdat;
    logic ack, cpu_en, mrun, srun, frun, lrun, flr, ilp, in_wait, in_stop;
    logic [NUM_PCLK-1:0] pclk;
    aux_clk_t aux;
    logic [3:0] osc = 4'h0;
    int oc [4] = '{0, 0, 0, 0};
    // half periods in sys_clk cycles: main, sub, fast, slow; all >= 2 for the synchroniser
    int half [4] = '{3, 5, 2, 4};
    int rat [5] = '{1, 2, 4, 16, 8};
    // watched pulses: 0 cpu, 1..5 f1..f32, 6 sub32, 7 sub4, 8 div128, 9 sup, 10 conv, 11 fast, 12 aux
    wire logic [12:0] w = {aux, pclk, cpu_en};
    note_t q[$];
    note_t cur;
    int fails = 0, n_compared = 0;

    clock_mode_ctrl i_clock_mode_ctrl (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .main_crystal_clock(osc[0]), .sub_crystal_clock(osc[1]), .fast_osc_clock(osc[2]),
        .slow_osc_clock(osc[3]), .wake_event(wake), .cpu_clk_en(cpu_en), .periph_clk(pclk),
        .aux_clk(aux), .main_crystal_run(mrun), .sub_crystal_run(srun), .fast_osc_run(frun),
        .slow_osc_run(lrun), .flash_low_current_read(flr), .internal_low_power_enable(ilp),
        .in_wait(in_wait), .in_stop(in_stop)
    );

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // oscillators run free; the block gates them itself
    always @(posedge sys_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (oc[i] >= half[i] - 1) begin
                osc[i] <= ~osc[i];
                oc[i] <= 0;
            end else begin
                oc[i] <= oc[i] + 1;
            end
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic timeout();
        fails++;
        $display("unexpected timeout: expected progress seen none");
        summarize();
    endtask

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // results arrive in issue order, so the oldest note is the one to compare
    always @(posedge sys_clk) begin
        if ((ack === 1'b1 && cyc && !we) || mstb) begin
            if (q.size() == 0) begin
                check("note_queue", 32'h1, 32'h0);
            end else begin
                cur = q.pop_front();
                check(cur.name, mstb ? mval : rdat, cur.v);
            end
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic bus(logic wr_, logic [7:0] a, logic [31:0] d);
        int k;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr_;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (ack === 1'b1) break;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k == 20) timeout();
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] exp, string name);
        q.push_back('{name, exp});
        bus(1'b0, a, 32'h0);
    endtask

    task automatic note(string name, logic [31:0] seen, logic [31:0] exp);
        q.push_back('{name, exp});
        @(posedge sys_clk);
        mval <= seen;
        mstb <= 1'b1;
        @(posedge sys_clk);
        mstb <= 1'b0;
    endtask

    // pulses of c within one period of r, half-open so the phase does not matter
    task automatic ratio(string name, int r, int c, int exp);
        int k;
        int n;
        k = 0;
        n = 0;
        // skip two reference pulses: a boundary on the write edge still keeps the old setting
        repeat (2) begin
            do begin
                @(posedge sys_clk);
                k++;
            end while (w[r] !== 1'b1 && k < 4000);
        end
        do begin
            @(posedge sys_clk);
            k++;
            n += (w[c] === 1'b1);
        end while (w[r] !== 1'b1 && k < 8000);
        if (k >= 8000) timeout();
        else note(name, 32'(n), 32'(exp));
    endtask

    task automatic burst(string name, int c, bit on);
        int n;
        n = 0;
        repeat (80) begin
            @(posedge sys_clk);
            n += (w[c] === 1'b1);
        end
        note(name, 32'(n > 0), 32'(on));
    endtask

    task automatic wake_up();
        wake <= 1'b1;
        @(posedge sys_clk);
        wake <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        int r;
        logic [7:0] a;
        void'($urandom(88671));
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(OFS_CTRL, 32'h0000_0241, "ctrl_reset");
        rd(OFS_STAT, 32'h0000_0837, "stat_reset");
        note("main_run_reset", mrun, 32'h0);
        for (r = 0; r < 5; r++) begin
            wr(OFS_CTRL, 32'h0000_0200 | (r == 4 ? 32'h7 : 32'(r << 1)));
            ratio("cpu_ratio", 0, 1, rat[r]);
            rd(OFS_STAT, 32'(rat[r] - 1) | 32'h0000_0830, "stat_ratio");
        end
        for (r = 1; r < 5; r++) ratio("periph_ratio", 5, r, 32 >> (r - 1));
        ratio("aux_div128", 8, 12, 128);
        ratio("aux_rate", 4, 12, 8);
        for (r = 0; r < 2; r++) begin
            wr(OFS_CTRL, 32'h0000_0241 | 32'(r << 3));
            wr(OFS_CMD, 32'h1);
            repeat (4) @(posedge sys_clk);
            burst("wait_cpu", 0, 1'b0);
            burst("wait_f1", 1, r == 0);
            burst("wait_aux", 12, 1'b1);
            note("in_wait", in_wait, 32'h1);
            wake_up();
        end
        // divide by eight set before every source family change
        wr(OFS_CTRL, 32'h0000_0E41);
        ratio("fast_cpu", 0, 1, 8);
        rd(OFS_STAT, 32'h0000_0C27, "stat_fast");
        note("fast_run", frun, 32'h1);
        ratio("fast_timer", 4, 11, 8);
        ratio("conv_clk", 4, 10, 8);
        burst("sup_on", 9, 1'b1);
        wr(OFS_CTRL, 32'h0000_0E61);
        repeat (4) @(posedge sys_clk);
        note("slow_off", lrun, 32'h0);
        burst("sup_off", 9, 1'b0);
        ratio("aux_fast", 4, 12, 8);
        // fast oscillator kept on until the cpu has left it
        wr(OFS_CTRL, 32'h0000_0611);
        repeat (100) @(posedge sys_clk);
        note("main_run", mrun, 32'h1);
        wr(OFS_CTRL, 32'h0000_0011);
        ratio("main_cpu", 0, 1, 8);
        wr(OFS_CTRL, 32'h0000_0012);
        ratio("main_div2", 0, 1, 2);
        rd(OFS_STAT, 32'h0000_0901, "stat_main");
        wr(OFS_CMD, 32'h2);
        repeat (4) @(posedge sys_clk);
        note("in_stop", in_stop, 32'h1);
        note("stop_main", mrun, 32'h0);
        wake_up();
        rd(OFS_CTRL, 32'h0000_0013, "div8_auto");
        // main crystal kept running until the cpu has left it
        wr(OFS_CTRL, 32'h0000_0211);
        wr(OFS_CTRL, 32'h0000_0391);
        repeat (100) @(posedge sys_clk);
        wr(OFS_CTRL, 32'h0000_01C1);
        ratio("sub_cpu", 0, 1, 8);
        ratio("sub_div", 6, 7, 8);
        rd(OFS_STAT, 32'h0000_0A17, "stat_sub");
        note("sub_run", srun, 32'h1);
        a = 8'($urandom_range(63, 3) * 4);
        wr(a, $urandom());
        rd(a, 32'h0, "unmapped");
        rd(OFS_CMD, 32'h0, "cmd_read");
        wr(OFS_CTRL, 32'h0000_FFFF);
        rd(OFS_CTRL, 32'h0000_3FFF, "ctrl_rsvd");
        note("flash_lc", flr, 32'h1);
        note("low_power", ilp, 32'h1);
        // second reset in mid-run must restore the start-up clocking
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(OFS_CTRL, 32'h0000_0241, "ctrl_rereset");
        note("slow_run", lrun, 32'h1);
        summarize();
    end
endmodule // tb_clock_mode_ctrl
`default_nettype wire
